// file: core/tcs_pkg.sv
// Package: constants and carriers for the torque cutoff supervisor
package tcs_pkg;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int CHECK_MIN_MS = 11;
   localparam int CHECK_MAX_MS = 100;
   localparam int BLINK_HALF_MS = 250;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CYC_PER_MS;
   localparam int DELAY_W = 7;
   localparam int MS_CNT_W = 14;
   localparam int BLINK_W = 22;

   // -----------------------------------------------------------------
   // Modes and reset sources
   // -----------------------------------------------------------------
   localparam logic MODE_CUTOFF = 1'h0;
   localparam logic MODE_ALARM_SHUTDOWN = 1'h1;
   localparam logic [1:0] RST_SRC_ALARM_CLEAR = 2'h0;
   localparam logic [1:0] RST_SRC_STOP_CMD = 2'h1;
   localparam logic [1:0] RST_SRC_CUTOFF_RESET = 2'h2;

   // Supervisor states
   typedef enum logic [2:0] {
      TCS_NORMAL = 3'h0,
      TCS_CUTOFF = 3'h1,
      TCS_WAIT_STOP = 3'h2,
      TCS_WAIT_RELEASE = 3'h3,
      TCS_ALARM = 3'h4
   } tcs_state_e;

   // Synchronised field inputs travel together
   typedef struct packed {
      logic stop_a;
      logic stop_b;
      logic alarm_clear;
      logic stop_cmd;
      logic cutoff_reset;
   } tcs_inputs_s;

   localparam int IN_W = $bits(tcs_inputs_s);

   // Status outputs travel together
   typedef struct packed {
      logic excitation;
      logic stop_monitor;
      logic circuit_alarm;
      logic ready;
      logic direct_ready;
      logic pulse_ready;
      logic indicator;
   } tcs_status_s;

endpackage

// file: core/tcs_sync.sv
// Two-stage synchroniser bank for asynchronous field inputs
`timescale 1ns/10ps
module tcs_sync #(
   parameter int WIDTH = 5
) (
   input wire logic clk_sys, // System clock
   input wire logic reset_n, // Asynchronous reset, active low
   input wire logic [WIDTH-1:0] async_in, // Raw pin levels
   output logic [WIDTH-1:0] sync_out // Levels safe to use
);

   // -----------------------------------------------------------------
   // Per-bit two flop chain
   // -----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         logic meta_reg;
         // First stage is only read by the second stage
         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               meta_reg <= 1'h0;
               sync_out[gi] <= 1'h0;
            end else begin
               meta_reg <= async_in[gi];
               sync_out[gi] <= meta_reg;
            end
         end
      end
   endgenerate

endmodule // tcs_sync

// file: core/tcs_supervisor.sv
// Dual-channel torque cutoff supervisor with recovery sequencing
// How it works
// - Both stops off: cut torque, monitor on
// - One stop off: monitor off, alarm if delay valid
// - Both on again: cutoff exit follows cutoff mode select
// - Mode 0: configured reset rising edge exits if no alarm is latched
// - Any stop off: reset edge ignored
// - Mode 1: only alarm clear edge exits
// - Stop command then restores motor excitation
// - Stop command release raises three readies
// - Indicator blinks green during cutoff
`timescale 1ns/10ps
module tcs_supervisor #(
   parameter int BLINK_HALF = tcs_pkg::BLINK_HALF_CYC, // Indicator half period
   parameter int MS_CYCLES = tcs_pkg::CYC_PER_MS // Cycles per millisecond
) (
   input wire logic clk_sys, // System clock, 10 MHz
   input wire logic reset_n, // Asynchronous reset, active low
   input wire logic safety_stop_in_a, // Redundant stop A, high = ON
   input wire logic safety_stop_in_b, // Redundant stop B, high = ON
   input wire logic alarm_clear_in, // Alarm clear, rising edge acts
   input wire logic stop_cmd_in, // Stop command input
   input wire logic cutoff_reset_in, // Dedicated cutoff reset input
   input wire logic cutoff_mode_select, // 0 cutoff mode, 1 alarm-shutdown
   input wire logic [1:0] cutoff_reset_source, // Signal used as reset action
   input wire logic [6:0] check_delay_ms, // Dual-channel check delay
   output logic motor_excitation_out, // High lets power reach the motor
   output logic stop_monitor_out, // Monitor, high = ON
   output logic torque_cutoff, // High while in cutoff state
   output logic circuit_alarm_out, // Emergency stop circuit alarm
   output logic ready_out, // General ready
   output logic direct_cmd_ready_out, // Direct command ready
   output logic pulse_cmd_ready_out, // Pulse command ready
   output logic power_alarm_indicator // Green indicator drive
);

   // -----------------------------------------------------------------
   // Input synchronisation
   // -----------------------------------------------------------------
   tcs_pkg::tcs_inputs_s raw_in;
   tcs_pkg::tcs_inputs_s syn_in;
   tcs_pkg::tcs_inputs_s prev_reg;
   logic [tcs_pkg::IN_W-1:0] syn_bits;

   assign raw_in = '{stop_a: safety_stop_in_a, stop_b: safety_stop_in_b,
                     alarm_clear: alarm_clear_in, stop_cmd: stop_cmd_in,
                     cutoff_reset: cutoff_reset_in};

   tcs_sync #(.WIDTH(tcs_pkg::IN_W)) u_sync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .async_in(raw_in),
      .sync_out(syn_bits)
   );
   assign syn_in = syn_bits;

   // Previous synchronised levels for edge detection
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= syn_in;
      end
   end

   logic [2:0] warm_reg;
   logic sync_ready;

   // Sync flops and edge history reset to OFF, not to the pins' idle level;
   // decisions wait until both carry real pin values, else reset fakes a cutoff
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         warm_reg <= '0;
      end else begin
         warm_reg <= {warm_reg[1:0], 1'h1};
      end
   end
   assign sync_ready = warm_reg[2];

   // -----------------------------------------------------------------
   // Level and edge decode
   // -----------------------------------------------------------------
   logic both_on;
   logic both_off;
   logic one_off;
   logic clear_edge;
   logic stop_fall;
   logic stop_rise;
   logic reset_edge;
   logic delay_valid;

   assign both_on = syn_in.stop_a & syn_in.stop_b;
   assign both_off = ~syn_in.stop_a & ~syn_in.stop_b;
   assign one_off = syn_in.stop_a ^ syn_in.stop_b;
   assign clear_edge = syn_in.alarm_clear & ~prev_reg.alarm_clear;
   assign stop_rise = syn_in.stop_cmd & ~prev_reg.stop_cmd;
   assign stop_fall = ~syn_in.stop_cmd & prev_reg.stop_cmd;
   assign delay_valid = (check_delay_ms >= 7'(tcs_pkg::CHECK_MIN_MS)) &&
                        (check_delay_ms <= 7'(tcs_pkg::CHECK_MAX_MS));

   // Configured reset action picks one of the synchronised inputs
   always_comb begin
      unique case (cutoff_reset_source)
         tcs_pkg::RST_SRC_ALARM_CLEAR: reset_edge = clear_edge;
         tcs_pkg::RST_SRC_STOP_CMD: reset_edge = stop_rise;
         tcs_pkg::RST_SRC_CUTOFF_RESET:
            reset_edge = syn_in.cutoff_reset & ~prev_reg.cutoff_reset;
         default: reset_edge = 1'h0;
      endcase
   end

   // -----------------------------------------------------------------
   // Dual-channel mismatch timer, one tick per millisecond
   // -----------------------------------------------------------------
   logic [tcs_pkg::MS_CNT_W-1:0] ms_cnt_reg;
   logic [tcs_pkg::DELAY_W-1:0] mis_ms_reg;
   logic mismatch_due;

   // Counts only while channels disagree, so a clean pair never alarms
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ms_cnt_reg <= '0;
         mis_ms_reg <= '0;
      end else if (!one_off) begin
         ms_cnt_reg <= '0;
         mis_ms_reg <= '0;
      end else if (ms_cnt_reg == tcs_pkg::MS_CNT_W'(MS_CYCLES - 1)) begin
         ms_cnt_reg <= '0;
         if (mis_ms_reg != '1) begin
            mis_ms_reg <= mis_ms_reg + 7'h01;
         end
      end else begin
         ms_cnt_reg <= ms_cnt_reg + 14'h0001;
      end
   end
   assign mismatch_due = one_off && delay_valid && (mis_ms_reg >= check_delay_ms);

   // -----------------------------------------------------------------
   // Supervisor state machine
   // -----------------------------------------------------------------
   tcs_pkg::tcs_state_e state_reg;
   tcs_pkg::tcs_state_e state_next;
   logic alarm_reg;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         tcs_pkg::TCS_NORMAL: begin
            if (both_off) begin
               state_next = tcs_pkg::TCS_CUTOFF;
            end else if (mismatch_due) begin
               state_next = tcs_pkg::TCS_ALARM;
            end
         end
         tcs_pkg::TCS_CUTOFF: begin
            // A mismatch here only sets the sticky alarm; no exit with a stop OFF
            if (!both_on) begin
               state_next = tcs_pkg::TCS_CUTOFF;
            end else if (cutoff_mode_select == tcs_pkg::MODE_ALARM_SHUTDOWN) begin
               if (clear_edge) begin
                  state_next = tcs_pkg::TCS_WAIT_STOP;
               end
            end else if (reset_edge && !alarm_reg) begin
               state_next = tcs_pkg::TCS_WAIT_STOP;
            end
         end
         tcs_pkg::TCS_WAIT_STOP: begin
            if (both_off) begin
               state_next = tcs_pkg::TCS_CUTOFF;
            end else if (mismatch_due) begin
               state_next = tcs_pkg::TCS_ALARM;
            end else if (both_on && syn_in.stop_cmd) begin
               state_next = tcs_pkg::TCS_WAIT_RELEASE;
            end
         end
         tcs_pkg::TCS_WAIT_RELEASE: begin
            if (both_off) begin
               state_next = tcs_pkg::TCS_CUTOFF;
            end else if (mismatch_due) begin
               state_next = tcs_pkg::TCS_ALARM;
            end else if (stop_fall) begin
               state_next = tcs_pkg::TCS_NORMAL;
            end
         end
         tcs_pkg::TCS_ALARM: begin
            if (both_off) begin
               state_next = tcs_pkg::TCS_CUTOFF;
            end else if (clear_edge && both_on) begin
               state_next = tcs_pkg::TCS_WAIT_STOP;
            end
         end
         default: state_next = tcs_pkg::TCS_CUTOFF;
      endcase
      // Hold the state until the sync pipe and edge history hold real levels
      if (!sync_ready) begin
         state_next = state_reg;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= tcs_pkg::TCS_NORMAL;
      end else begin
         state_reg <= state_next;
      end
   end

   // Alarm is sticky: a new mismatch wins over a clear in the same cycle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         alarm_reg <= 1'h0;
      end else if (mismatch_due) begin
         alarm_reg <= 1'h1;
      end else if (clear_edge && both_on) begin
         alarm_reg <= 1'h0;
      end
   end

   // -----------------------------------------------------------------
   // Indicator blink divider
   // -----------------------------------------------------------------
   logic [tcs_pkg::BLINK_W-1:0] blink_cnt_reg;
   logic blink_reg;

   // Free running so the blink phase is independent of entry time
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         blink_cnt_reg <= '0;
         blink_reg <= 1'h0;
      end else if (blink_cnt_reg == tcs_pkg::BLINK_W'(BLINK_HALF - 1)) begin
         blink_cnt_reg <= '0;
         blink_reg <= ~blink_reg;
      end else begin
         blink_cnt_reg <= blink_cnt_reg + 22'h000001;
      end
   end

   // -----------------------------------------------------------------
   // Registered outputs, decoded from next state and live levels
   // -----------------------------------------------------------------
   tcs_pkg::tcs_status_s st_next;
   logic in_cut;
   logic runs;

   always_comb begin
      in_cut = (state_next == tcs_pkg::TCS_CUTOFF);
      runs = (state_next == tcs_pkg::TCS_NORMAL);
      // Excitation needs both channels ON; any OFF removes it at once
      st_next.excitation = both_on && (runs || state_next == tcs_pkg::TCS_WAIT_RELEASE);
      st_next.stop_monitor = both_off && sync_ready;
      st_next.circuit_alarm = alarm_reg || mismatch_due;
      st_next.ready = runs && both_on;
      st_next.direct_ready = runs && both_on;
      st_next.pulse_ready = runs && both_on;
      st_next.indicator = in_cut ? blink_reg : 1'h1;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         motor_excitation_out <= 1'h0;
         stop_monitor_out <= 1'h0;
         torque_cutoff <= 1'h0;
         circuit_alarm_out <= 1'h0;
         ready_out <= 1'h0;
         direct_cmd_ready_out <= 1'h0;
         pulse_cmd_ready_out <= 1'h0;
         power_alarm_indicator <= 1'h0;
      end else begin
         motor_excitation_out <= st_next.excitation;
         stop_monitor_out <= st_next.stop_monitor;
         torque_cutoff <= in_cut;
         circuit_alarm_out <= st_next.circuit_alarm;
         ready_out <= st_next.ready;
         direct_cmd_ready_out <= st_next.direct_ready;
         pulse_cmd_ready_out <= st_next.pulse_ready;
         power_alarm_indicator <= st_next.indicator;
      end
   end

endmodule // tcs_supervisor

// file: verification/tcs_supervisor_props.sv
// Port-level checker for the torque cutoff supervisor
`timescale 1ns/10ps
module tcs_supervisor_props (
   input wire logic clk_sys, // System clock
   input wire logic reset_n, // Reset, active low
   input wire logic safety_stop_in_a, // Stop A pin
   input wire logic safety_stop_in_b, // Stop B pin
   input wire logic alarm_clear_in, // Alarm clear pin
   input wire logic cutoff_mode_select, // Mode select
   input wire logic [6:0] check_delay_ms, // Check delay
   input wire logic motor_excitation_out, // Excitation
   input wire logic stop_monitor_out, // Monitor
   input wire logic torque_cutoff, // Cutoff state
   input wire logic circuit_alarm_out, // Circuit alarm
   input wire logic ready_out, // General ready
   input wire logic direct_cmd_ready_out, // Direct ready
   input wire logic pulse_cmd_ready_out, // Pulse ready
   input wire logic power_alarm_indicator // Indicator
);
   // -----------------------------------------------------------------
   // Relations; windows of five cover the two sync flops plus output
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   a_both_off_cut: assert property (
      (!safety_stop_in_a && !safety_stop_in_b)[*5]
      |-> stop_monitor_out && torque_cutoff && !motor_excitation_out) else $error("no cutoff");
   a_both_on_quiet: assert property (
      (safety_stop_in_a && safety_stop_in_b)[*5] |-> !stop_monitor_out) else $error("monitor on");
   a_single_off_dark: assert property (
      (safety_stop_in_a != safety_stop_in_b)[*5]
      |-> !motor_excitation_out && !stop_monitor_out) else $error("single off wrong");
   a_cutoff_not_ready: assert property (
      torque_cutoff |-> !motor_excitation_out && !ready_out) else $error("cutoff excites");
   a_exit_needs_stops: assert property (
      $fell(torque_cutoff) |-> $past(safety_stop_in_a, 3) && $past(safety_stop_in_b, 3))
      else $error("exit with stop off");
   a_mode_one_exit: assert property (
      $fell(torque_cutoff) && cutoff_mode_select
      |-> $past(alarm_clear_in, 3) && !$past(alarm_clear_in, 4)) else $error("bad exit");
   a_alarm_cause: assert property (
      $rose(circuit_alarm_out) |-> $past(safety_stop_in_a, 3) != $past(safety_stop_in_b, 3)
      && check_delay_ms >= 7'h0B && check_delay_ms <= 7'h64) else $error("alarm uncaused");
   a_readies_agree: assert property (
      ready_out == direct_cmd_ready_out && ready_out == pulse_cmd_ready_out)
      else $error("readies differ");
   a_blink_cutoff: assert property (
      not ((torque_cutoff && $stable(power_alarm_indicator))[*7])) else $error("no blink");
   a_alarm_dark: assert property (
      circuit_alarm_out |-> !motor_excitation_out) else $error("alarm excites");
endmodule // tcs_supervisor_props

// file: verification/tcs_field_model.sv
// Safety contacts and monitor supervision on the far side of the block
`timescale 1ns/10ps
module tcs_field_model (
   input wire logic clk_sys, // System clock
   input wire logic reset_n, // Reset, active low
   input wire logic open_a, // Contact A opened
   input wire logic open_b, // Contact B opened
   input wire logic stop_monitor_out, // Monitor from block
   output logic safety_stop_in_a, // Stop A pin
   output logic safety_stop_in_b, // Stop B pin
   output int fn_err // Function errors seen
);
   logic [1:0] last_reg;
   int settle_reg;
   // Closed contact reads ON
   assign safety_stop_in_a = !open_a;
   assign safety_stop_in_b = !open_b;
   // Judge the monitor only after pins settle, or sync lag looks like a fault
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         last_reg <= 2'h0;
         settle_reg <= 0;
         fn_err <= 0;
      end else begin
         last_reg <= {safety_stop_in_a, safety_stop_in_b};
         settle_reg <= (last_reg != {safety_stop_in_a, safety_stop_in_b}) ? 0 : settle_reg + 1;
         if (settle_reg > 5 && stop_monitor_out != (last_reg == 2'h0)) begin
            fn_err <= fn_err + 1;
         end
      end
   end
endmodule // tcs_field_model

// file: verification/tcs_supervisor_tb_top.sv
// Self-checking bench for the torque cutoff supervisor
`timescale 1ns/10ps
module tcs_supervisor_tb_top;
   logic clk_sys = 1'h0;
   logic reset_n = 1'h0;
   logic open_a = 1'h0;
   logic open_b = 1'h0;
   logic alarm_clear_in = 1'h0;
   logic stop_cmd_in = 1'h0;
   logic cutoff_reset_in = 1'h0;
   logic cutoff_mode_select = 1'h0;
   logic [1:0] cutoff_reset_source = 2'h2;
   logic [6:0] check_delay_ms = 7'h0C;
   logic safety_stop_in_a, safety_stop_in_b, motor_excitation_out, stop_monitor_out;
   logic torque_cutoff, circuit_alarm_out, ready_out, direct_cmd_ready_out;
   logic pulse_cmd_ready_out, power_alarm_indicator, exp_al;
   int fn_err, error_cnt = 0, n_checks = 0, cycles = 0;
   int dl[4] = '{11, 10, 101, 100};
   // Short counts keep the millisecond timer and blink inside the run
   tcs_supervisor #(.BLINK_HALF(4), .MS_CYCLES(10)) tcs_supervisor_inst (.*);
   tcs_field_model tcs_field_model_inst (.*);
   // Clock and hang guard
   always #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         final_report();
      end
   end
   // -----------------------------------------------------------------
   // Tasks; inputs move on the falling edge
   // -----------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic chk(input string nm, input logic ex, input logic got);
      n_checks++;
      if (got !== ex) begin
         error_cnt++;
         $display("wrong value %s expected %b seen %b", nm, ex, got);
      end
   endtask
   task automatic st(input logic ex, input logic mon, input logic cut, input logic rdy);
      chk("excitation", ex, motor_excitation_out);
      chk("monitor", mon, stop_monitor_out);
      chk("cutoff", cut, torque_cutoff);
      chk("ready", rdy, ready_out);
   endtask
   task automatic stops(input logic oa, input logic ob);
      open_a = oa;
      open_b = ob;
      cyc(8);
   endtask
   // Held long enough for the sync flops to see a clean edge
   task automatic fire(input logic [1:0] s);
      if (s == 2'h0) alarm_clear_in = 1'h1;
      if (s == 2'h1) stop_cmd_in = 1'h1;
      if (s == 2'h2) cutoff_reset_in = 1'h1;
      cyc(6);
      alarm_clear_in = 1'h0;
      stop_cmd_in = 1'h0;
      cutoff_reset_in = 1'h0;
      cyc(6);
   endtask
   task automatic rec();
      st(1'h0, 1'h0, 1'h0, 1'h0);
      stop_cmd_in = 1'h1;
      cyc(6);
      chk("excitation", 1'h1, motor_excitation_out);
      chk("ready", 1'h0, ready_out);
      stop_cmd_in = 1'h0;
      cyc(6);
      st(1'h1, 1'h0, 1'h0, 1'h1);
      chk("direct ready", 1'h1, direct_cmd_ready_out);
      chk("pulse ready", 1'h1, pulse_cmd_ready_out);
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      cyc(10);
      reset_n = 1'h1;
      cyc(8);
      st(1'h1, 1'h0, 1'h0, 1'h1);
      open_a = 1'h1;
      open_b = 1'h1;
      cyc(2);
      chk("monitor early", 1'h0, stop_monitor_out);
      for (int s = 0; s < 3; s++) begin
         cutoff_reset_source = 2'(s);
         stops(1'h1, 1'h1);
         st(1'h0, 1'h1, 1'h1, 1'h0);
         fire(2'(s));
         st(1'h0, 1'h1, 1'h1, 1'h0);
         stops(1'h0, 1'h0);
         fire(2'(s));
         chk("cutoff", 1'h0, torque_cutoff);
         if (s != 1) rec();
      end
      cutoff_mode_select = 1'h1;
      stops(1'h1, 1'h1);
      st(1'h0, 1'h1, 1'h1, 1'h0);
      stops(1'h0, 1'h0);
      fire(2'h2);
      chk("cutoff", 1'h1, torque_cutoff);
      fire(2'h0);
      chk("cutoff", 1'h0, torque_cutoff);
      rec();
      // Model count clears with reset, so judge it before the mid-run reset
      chk("monitor consistency", 1'h1, fn_err == 0);
      reset_n = 1'h0;
      cyc(2);
      reset_n = 1'h1;
      cyc(4);
      st(1'h1, 1'h0, 1'h0, 1'h1);
      cutoff_mode_select = 1'h0;
      cutoff_reset_source = 2'h0;
      foreach (dl[i]) begin
         check_delay_ms = 7'(dl[i]);
         exp_al = (dl[i] >= tcs_pkg::CHECK_MIN_MS && dl[i] <= tcs_pkg::CHECK_MAX_MS);
         stops(1'h0, 1'h1);
         chk("excitation", 1'h0, motor_excitation_out);
         chk("monitor", 1'h0, stop_monitor_out);
         cyc(dl[i] * 10 + 20);
         chk("alarm", exp_al, circuit_alarm_out);
         stops(1'h0, 1'h0);
         fire(2'h0);
         chk("alarm", 1'h0, circuit_alarm_out);
         if (exp_al) rec();
      end
      chk("monitor consistency", 1'h1, fn_err == 0);
      final_report();
   end
endmodule // tcs_supervisor_tb_top

bind tcs_supervisor tcs_supervisor_props tcs_supervisor_props_inst (.*);
